// *** design/rtc_pkg.sv ***
// constants, field layout and state codes for the serial clock/calendar slave
// assumes: included by the slave top before any module that imports it
package rtc_pkg;
   localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hD0;
   localparam int NUM_REGS = 8;
   localparam int PTR_W = 3;
   localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   localparam logic [2:0] REG_SEC = 3'h0;
   localparam logic [2:0] REG_MIN = 3'h1;
   localparam logic [2:0] REG_HOUR = 3'h2;
   localparam logic [2:0] REG_DAY = 3'h3;
   localparam logic [2:0] REG_DATE = 3'h4;
   localparam logic [2:0] REG_MONTH = 3'h5;
   localparam logic [2:0] REG_YEAR = 3'h6;
   localparam logic [2:0] REG_CTRL = 3'h7;

   localparam int HALT_BIT = 7;
   localparam int CEB_BIT = 7;
   localparam int CB_BIT = 6;

   // don't-care bits are dropped on write so they read back as zero; index 0 is seconds
   localparam logic [7:0][7:0] REG_MASK = {8'hFF, 8'hFF, 8'h1F, 8'h3F, 8'h07, 8'hFF, 8'h7F, 8'hFF};
   localparam logic [7:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] SEC_MAX = 8'h59;
   localparam logic [7:0] MIN_MAX = 8'h59;
   localparam logic [7:0] HOUR_MAX = 8'h23;
   localparam logic [7:0] DAY_MAX = 8'h07;
   localparam logic [7:0] MONTH_MAX = 8'h12;
   localparam logic [7:0] YEAR_MAX = 8'h99;
   localparam logic [7:0] DATE_LONG = 8'h31;
   localparam logic [7:0] DATE_SHORT = 8'h30;
   localparam logic [7:0] DATE_FEB_LEAP = 8'h29;
   localparam logic [7:0] DATE_FEB = 8'h28;
   localparam logic [7:0] MON_FEB = 8'h02;
   localparam logic [7:0] MON_APR = 8'h04;
   localparam logic [7:0] MON_JUN = 8'h06;
   localparam logic [7:0] MON_SEP = 8'h09;
   localparam logic [7:0] MON_NOV = 8'h11;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_ADDR = 3'b001,
      PH_PTR = 3'b010,
      PH_WDATA = 3'b011,
      PH_RDATA = 3'b100,
      PH_IGNORE = 3'b101
   } phase_e;
endpackage : rtc_pkg

// *** design/rtc_serial_slave.sv ***
// two-wire serial slave front end and eight-byte bcd clock/calendar register file
// assumes: scl_clk is the bus clock pin used as the link clock, sda is open drain with
// an external pull-up, main_supply_ok and second_tick come from outside the clk domain
`timescale 1ns/1ns
module rtc_serial_slave
   import rtc_pkg::*;
#(
   parameter logic [7:0] DEVICE_ADDR = rtc_pkg::SLAVE_ADDR_BYTE
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic main_supply_ok,
   input wire logic second_tick
);
   import rtc_pkg::*;

   generate
      if (DEVICE_ADDR[0] != 1'b0) begin : g_bad_addr
         $error("DEVICE_ADDR must have a zero direction bit");
      end
   endgenerate

   // link domain: sample the data line on each rising serial clock edge
   typedef struct packed {
      logic bit_val;
      logic tog;
   } link_s;

   link_s lk_ff, nxt_lk;

   always_comb begin
      nxt_lk = lk_ff;
      nxt_lk.bit_val = sda_i;
      nxt_lk.tog = ~lk_ff.tog; // one event per clock pulse
   end

   always_ff @(posedge scl_clk or negedge reset_n) begin
      if (!reset_n) begin
         lk_ff <= '0;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   typedef struct packed {
      phase_e phase;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] tx;
      logic [PTR_W-1:0] ptr;
      logic ack_pend;
      logic sda_oe;
      logic sda_o;
      logic [NUM_REGS-1:0][7:0] regs;
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic [2:0] tog_sync;
      logic [2:0] tick_sync;
      logic [1:0] pwr_sync;
   } state_s;

   state_s st_ff, nxt_st;

   function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
      if (v >= hi) begin
         return {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         return {1'b0, v[7:4], v[3:0] + 4'h1};
      end
   endfunction : bcd_step

   function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         MON_FEB: return leap ? DATE_FEB_LEAP : DATE_FEB;
         MON_APR, MON_JUN, MON_SEP, MON_NOV: return DATE_SHORT;
         default: return DATE_LONG;
      endcase
   endfunction : month_len

   // events seen by the clk domain; only the second and third sync stages are read
   logic scl_hi, start_ev, stop_ev, fall_ev, bit_ev, tick_ev, pwr_ok;
   logic [7:0] sh_byte;
   logic byte_done, ack_slot_ev, addr_hit, addr_miss, ptr_load, wdata_done, rd_ack, rd_nack;
   logic tick_run, bus_live;
   logic [PTR_W-1:0] ptr_inc;
   logic [8:0] s_sec, s_min, s_hr, s_day, s_date, s_mon, s_yr;

   assign scl_hi = st_ff.scl_sync[1];
   assign start_ev = scl_hi && st_ff.scl_sync[2] && st_ff.sda_sync[2] && !st_ff.sda_sync[1];
   assign stop_ev = scl_hi && st_ff.scl_sync[2] && !st_ff.sda_sync[2] && st_ff.sda_sync[1];
   assign fall_ev = st_ff.scl_sync[2] && !st_ff.scl_sync[1];
   assign bit_ev = st_ff.tog_sync[2] ^ st_ff.tog_sync[1];
   assign tick_ev = st_ff.tick_sync[1] && !st_ff.tick_sync[2];
   assign pwr_ok = st_ff.pwr_sync[1];
   assign sh_byte = {st_ff.shreg[6:0], lk_ff.bit_val};
   assign ptr_inc = st_ff.ptr + 3'h1; // wraps control back to seconds

   assign bus_live = pwr_ok && !start_ev && !stop_ev && bit_ev
                     && st_ff.phase != PH_IDLE && st_ff.phase != PH_IGNORE;
   assign byte_done = bus_live && st_ff.cnt == BYTE_LAST_BIT;
   assign ack_slot_ev = bus_live && st_ff.cnt == ACK_SLOT;
   assign addr_hit = byte_done && st_ff.phase == PH_ADDR && sh_byte[7:1] == DEVICE_ADDR[7:1];
   assign addr_miss = byte_done && st_ff.phase == PH_ADDR && sh_byte[7:1] != DEVICE_ADDR[7:1];
   assign ptr_load = byte_done && st_ff.phase == PH_PTR;
   assign wdata_done = byte_done && st_ff.phase == PH_WDATA;
   assign rd_ack = ack_slot_ev && st_ff.phase == PH_RDATA && !st_ff.ack_pend && !lk_ff.bit_val;
   assign rd_nack = ack_slot_ev && st_ff.phase == PH_RDATA && !st_ff.ack_pend && lk_ff.bit_val;
   assign tick_run = tick_ev && !st_ff.regs[REG_SEC][HALT_BIT];

   // bcd step of every field; each carry feeds the next field, but day and date both step on the hour carry
   assign s_sec = bcd_step({1'b0, st_ff.regs[REG_SEC][6:0]}, BCD_ZERO, SEC_MAX);
   assign s_min = bcd_step(st_ff.regs[REG_MIN], BCD_ZERO, MIN_MAX);
   assign s_hr = bcd_step({2'b00, st_ff.regs[REG_HOUR][5:0]}, BCD_ZERO, HOUR_MAX);
   assign s_day = bcd_step(st_ff.regs[REG_DAY], BCD_ONE, DAY_MAX);
   assign s_date = bcd_step(st_ff.regs[REG_DATE], BCD_ONE,
                            month_len(st_ff.regs[REG_MONTH], st_ff.regs[REG_YEAR]));
   assign s_mon = bcd_step(st_ff.regs[REG_MONTH], BCD_ONE, MONTH_MAX);
   assign s_yr = bcd_step(st_ff.regs[REG_YEAR], BCD_ZERO, YEAR_MAX);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.scl_sync = {st_ff.scl_sync[1:0], scl_clk};
      nxt_st.sda_sync = {st_ff.sda_sync[1:0], sda_i};
      nxt_st.tog_sync = {st_ff.tog_sync[1:0], lk_ff.tog};
      nxt_st.tick_sync = {st_ff.tick_sync[1:0], second_tick};
      nxt_st.pwr_sync = {st_ff.pwr_sync[0], main_supply_ok};
      nxt_st.sda_o = 1'b0; // open drain: only ever pulls low, never touches the clock line

      // counting keeps running on battery; only the bus is locked out
      if (tick_run) begin
         nxt_st.regs[REG_SEC][6:0] = s_sec[6:0];
         if (s_sec[8]) begin
            nxt_st.regs[REG_MIN] = s_min[7:0];
            if (s_min[8]) begin
               nxt_st.regs[REG_HOUR][5:0] = s_hr[5:0];
               if (s_hr[8]) begin
                  nxt_st.regs[REG_DAY] = s_day[7:0];
                  nxt_st.regs[REG_DATE] = s_date[7:0];
                  if (s_date[8]) begin
                     nxt_st.regs[REG_MONTH] = s_mon[7:0];
                     if (s_mon[8]) begin
                        nxt_st.regs[REG_YEAR] = s_yr[7:0];
                        if (s_yr[8] && st_ff.regs[REG_HOUR][CEB_BIT]) begin
                           nxt_st.regs[REG_HOUR][CB_BIT] = ~st_ff.regs[REG_HOUR][CB_BIT];
                        end
                     end
                  end
               end
            end
         end
      end

      if (!pwr_ok) begin
         // abort and lock out until supply returns
         nxt_st.phase = PH_IDLE;
         nxt_st.ptr = '0;
         nxt_st.cnt = '0;
         nxt_st.ack_pend = 1'b0;
         nxt_st.sda_oe = 1'b0;
      end else if (start_ev) begin
         nxt_st.phase = PH_ADDR; // also serves a repeated start
         nxt_st.cnt = '0;
         nxt_st.ack_pend = 1'b0;
         nxt_st.sda_oe = 1'b0;
      end else if (stop_ev) begin
         nxt_st.phase = PH_IDLE; // idle bus, nothing in progress
         nxt_st.cnt = '0;
         nxt_st.ack_pend = 1'b0;
         nxt_st.sda_oe = 1'b0;
      end else if (bus_live) begin
         if (st_ff.cnt < ACK_SLOT) begin
            nxt_st.shreg = sh_byte;
            nxt_st.cnt = st_ff.cnt + 4'h1;
            if (addr_hit) begin
               nxt_st.ack_pend = 1'b1;
               nxt_st.phase = sh_byte[0] ? PH_RDATA : PH_PTR;
               nxt_st.tx = st_ff.regs[st_ff.ptr]; // read begins at current pointer
            end else if (addr_miss) begin
               nxt_st.phase = PH_IGNORE;
            end else if (ptr_load) begin
               nxt_st.ptr = sh_byte[PTR_W-1:0];
               nxt_st.ack_pend = 1'b1;
               nxt_st.phase = PH_WDATA;
            end else if (wdata_done) begin
               nxt_st.regs[st_ff.ptr] = sh_byte & REG_MASK[st_ff.ptr];
               nxt_st.ptr = ptr_inc; // no limit on byte count
               nxt_st.ack_pend = 1'b1;
            end
         end else begin
            // ninth clock: our own acknowledge, or the master's answer to a read byte
            nxt_st.cnt = '0;
            nxt_st.ack_pend = 1'b0;
            if (rd_ack) begin
               nxt_st.ptr = ptr_inc;
               nxt_st.tx = st_ff.regs[ptr_inc];
            end else if (rd_nack) begin
               nxt_st.phase = PH_IGNORE; // wait for stop with the line released
            end
         end
      end else if (fall_ev) begin
         // drive only while the clock is low
         if (st_ff.phase == PH_RDATA && !st_ff.ack_pend && st_ff.cnt < ACK_SLOT) begin
            nxt_st.sda_oe = ~st_ff.tx[3'h7 - st_ff.cnt[2:0]];
         end else if (st_ff.ack_pend && st_ff.cnt == ACK_SLOT) begin
            nxt_st.sda_oe = 1'b1;
         end else begin
            nxt_st.sda_oe = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '{phase: PH_IDLE, regs: REG_RESET, scl_sync: 3'h7, sda_sync: 3'h7, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sda_o = st_ff.sda_o;
   assign sda_oe = st_ff.sda_oe;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_ack_due;
      st_ff.ack_pend && st_ff.cnt == ACK_SLOT && fall_ev && pwr_ok && !start_ev && !stop_ev;
   endsequence

   sequence s_ptr_step;
      st_ff.ptr == $past(ptr_inc);
   endsequence

   a_start_to_addr: assert property (start_ev && pwr_ok |=> st_ff.phase == PH_ADDR && st_ff.cnt == 4'h0)
      else $error("start not taken");
   a_stop_release: assert property (stop_ev && pwr_ok |=> st_ff.phase == PH_IDLE ##1 !st_ff.sda_oe)
      else $error("stop did not free the bus");
   a_power_abort: assert property (!pwr_ok |=> st_ff.ptr == 3'h0 && st_ff.phase == PH_IDLE && !st_ff.sda_oe)
      else $error("supply loss did not abort");
   a_power_lockout: assert property (!pwr_ok && !tick_run |=> st_ff.regs == $past(st_ff.regs))
      else $error("register changed while supply low");
   a_addr_select: assert property (addr_hit |=> st_ff.ack_pend ##0 st_ff.phase != PH_IGNORE)
      else $error("own address not acknowledged");
   a_addr_foreign: assert property (addr_miss |=> st_ff.phase == PH_IGNORE && !st_ff.ack_pend)
      else $error("foreign address answered");
   a_ack_drive: assert property (s_ack_due |=> st_ff.sda_oe)
      else $error("acknowledge not driven");
   a_ptr_load: assert property (ptr_load |=> st_ff.ptr == $past(sh_byte[2:0]))
      else $error("pointer not loaded");
   a_write_step: assert property (wdata_done |=> s_ptr_step)
      else $error("pointer did not advance on write");
   a_read_step: assert property (rd_ack |=> s_ptr_step ##0 st_ff.tx == st_ff.regs[st_ff.ptr])
      else $error("read did not advance on acknowledge");
   a_read_nack: assert property (rd_nack |=> st_ff.ptr == $past(st_ff.ptr) ##1 !st_ff.sda_oe[*2])
      else $error("nack did not release the line");
   a_sec_rollover: assert property (tick_run && st_ff.regs[REG_SEC][6:0] == 7'h59 && !wdata_done && pwr_ok
                                    |=> st_ff.regs[REG_SEC][6:0] == 7'h00)
      else $error("seconds did not roll over");
   a_halt_freeze: assert property (tick_ev && st_ff.regs[REG_SEC][HALT_BIT] && !wdata_done
                                   |=> st_ff.regs[REG_SEC] == $past(st_ff.regs[REG_SEC]))
      else $error("halted clock counted");

   // oe_cause and tx_bit give $past a plain signal instead of an expression; year_wrap names the full carry chain
   logic oe_cause, tx_bit, year_wrap;
   assign oe_cause = fall_ev || start_ev || stop_ev || !pwr_ok;
   assign tx_bit = st_ff.tx[3'h7 - st_ff.cnt[2:0]];
   assign year_wrap = tick_run && s_sec[8] && s_min[8] && s_hr[8] && s_date[8] && s_mon[8] && s_yr[8];

   sequence s_read_fall;
      st_ff.phase == PH_RDATA && !st_ff.ack_pend && st_ff.cnt < ACK_SLOT && fall_ev && pwr_ok && !bus_live
      && !start_ev && !stop_ev;
   endsequence

   sequence s_write_fall;
      st_ff.phase inside {PH_ADDR, PH_PTR, PH_WDATA} && !st_ff.ack_pend && fall_ev && pwr_ok && !bus_live
      && !start_ev && !stop_ev;
   endsequence

   sequence s_year_wrap;
      year_wrap && st_ff.regs[REG_HOUR][CEB_BIT] && !wdata_done;
   endsequence

   sequence s_cb_flipped;
      st_ff.regs[REG_HOUR][CB_BIT] != $past(st_ff.regs[REG_HOUR][CB_BIT]);
   endsequence

   // line driver: open drain, quiet when idle, moves only on a clock fall or a control event
   a_sda_o_low: assert property (!st_ff.sda_o)
      else $error("data output not held low");
   a_idle_quiet: assert property (st_ff.phase == PH_IDLE |-> !st_ff.sda_oe)
      else $error("line pulled on idle bus");
   a_oe_cause: assert property ($changed(st_ff.sda_oe) |-> $past(oe_cause))
      else $error("line moved without a clock fall");
   a_read_bit: assert property (s_read_fall |=> st_ff.sda_oe == !$past(tx_bit))
      else $error("read bit not driven");
   a_write_release: assert property (s_write_fall |=> !st_ff.sda_oe)
      else $error("line held while master sends");
   a_ignore_release: assert property (st_ff.phase == PH_IGNORE && fall_ev && pwr_ok && !start_ev && !stop_ev
                                      |=> !st_ff.sda_oe)
      else $error("line pulled while ignoring");
   a_start_release: assert property (start_ev && pwr_ok |=> !st_ff.sda_oe)
      else $error("line held over a start");

   // bit and byte framing
   a_cnt_range: assert property (st_ff.cnt <= ACK_SLOT)
      else $error("bit count out of range");
   a_bit_count: assert property (bus_live && st_ff.cnt < ACK_SLOT |=> st_ff.cnt == $past(st_ff.cnt) + 4'h1)
      else $error("bit not counted once");
   a_stop_clear: assert property (stop_ev && pwr_ok |=> st_ff.cnt == 4'h0 && !st_ff.ack_pend)
      else $error("stop left a byte open");
   a_power_clear: assert property (!pwr_ok |=> st_ff.cnt == 4'h0 && !st_ff.ack_pend)
      else $error("supply loss left a byte open");
   a_addr_dir: assert property (addr_hit |=> st_ff.phase == ($past(sh_byte[0]) ? PH_RDATA : PH_PTR))
      else $error("direction bit not followed");
   a_read_first: assert property (addr_hit && !tick_run |=> st_ff.tx == st_ff.regs[st_ff.ptr])
      else $error("read not at current pointer");
   a_idle_ptr: assert property (st_ff.phase == PH_IDLE && pwr_ok |=> st_ff.ptr == $past(st_ff.ptr))
      else $error("pointer moved on idle bus");

   // register file: writes are masked, nothing else moves the bytes but the tick
   a_write_mask: assert property (wdata_done
                                  |=> st_ff.regs[$past(st_ff.ptr)] == ($past(sh_byte) & REG_MASK[$past(st_ff.ptr)]))
      else $error("written byte not masked");
   a_ignore_regs: assert property (st_ff.phase == PH_IGNORE && !tick_run |=> st_ff.regs == $past(st_ff.regs))
      else $error("register changed while ignoring");
   a_tick_quiet: assert property (!tick_run && !wdata_done |=> st_ff.regs == $past(st_ff.regs))
      else $error("register changed without cause");

   // calendar carries
   a_min_rollover: assert property (tick_run && s_sec[8] && st_ff.regs[REG_MIN] == MIN_MAX && !wdata_done
                                    |=> st_ff.regs[REG_MIN] == BCD_ZERO)
      else $error("minutes did not roll over");
   a_hour_rollover: assert property (tick_run && s_sec[8] && s_min[8] && st_ff.regs[REG_HOUR][5:0] == HOUR_MAX[5:0]
                                     && !wdata_done |=> st_ff.regs[REG_HOUR][5:0] == 6'h00)
      else $error("hours did not roll over");
   a_date_wrap: assert property (tick_run && s_sec[8] && s_min[8] && s_hr[8] && s_date[8] && !wdata_done
                                 |=> st_ff.regs[REG_DATE] == BCD_ONE)
      else $error("date did not wrap");
   a_century_keep: assert property (tick_run && !st_ff.regs[REG_HOUR][CEB_BIT] && !wdata_done
                                    |=> st_ff.regs[REG_HOUR][CB_BIT] == $past(st_ff.regs[REG_HOUR][CB_BIT]))
      else $error("century flag moved while disabled");
   a_century_flip: assert property (s_year_wrap |=> s_cb_flipped)
      else $error("century flag did not flip");
endmodule : rtc_serial_slave

// *** dv/bus_master_model.sv ***
// two-wire bus master model: drives the serial clock and pulls the data line low
// assumes: data line is resolved outside with a pull-up; clock idles high between frames
`timescale 1ns/1ns
module bus_master_model #(
   parameter int HALF = 40
) (
   output logic scl,
   output logic sda_pull,
   input wire logic sda_line
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // also serves as repeated start: data released, clock raised, then data pulled
   task automatic start();
      sda_pull = 1'b0;
      #(HALF);
      scl = 1'b1;
      #(HALF);
      sda_pull = 1'b1;
      #(HALF);
      scl = 1'b0;
   endtask : start

   task automatic stop();
      sda_pull = 1'b1;
      #(HALF);
      scl = 1'b1;
      #(HALF);
      sda_pull = 1'b0;
      #(HALF);
   endtask : stop

   // data moves a quarter phase after the fall so no edge looks like a control condition
   task automatic clk_bit(input logic b, output logic s);
      #(HALF / 4);
      sda_pull = ~b;
      #(HALF - HALF / 4);
      scl = 1'b1;
      #(HALF / 2);
      s = sda_line;
      #(HALF / 2);
      scl = 1'b0;
   endtask : clk_bit

   // ack_in 1 releases the ninth bit: a nack when reading, room for the ack when writing
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack_out);
      for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
      clk_bit(ack_in, ack_out);
   endtask : xfer
endmodule : bus_master_model

// *** dv/tb_top.sv ***
// self-checking bench for the serial clock/calendar slave
// assumes: the master model owns the clock line; the data line has a pull-up here
`timescale 1ns/1ns
module tb_top;
   import rtc_pkg::*;
   logic clk, reset_n, supply_ok, tick, sda_o, sda_oe, m_pull, scl, sda;
   int failures = 0;
   int n_tests = 0;

   assign sda = ((sda_oe && !sda_o) || m_pull) ? 1'b0 : 1'b1;
   // the clock line has no driver on the device side
   bus_master_model m (.scl(scl), .sda_pull(m_pull), .sda_line(sda));
   rtc_serial_slave dut (.clk(clk), .reset_n(reset_n), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .main_supply_ok(supply_ok), .second_tick(tick));

   always #4 clk = ~clk;

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("Error at %0t: got %h, expected %h", $time, seen, exp);
         failures++;
      end
   endtask : check

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tk

   task automatic put(input logic [7:0] b, input logic ack_exp);
      logic [7:0] r;
      logic a;
      m.xfer(b, 1'b1, r, a);
      check({7'h00, a}, {7'h00, ack_exp});
   endtask : put

   task automatic set_ptr(input logic [7:0] p);
      m.start();
      put(SLAVE_ADDR_BYTE, 1'b0);
      put(p, 1'b0);
   endtask : set_ptr

   task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
      set_ptr(p);
      foreach (d[i]) put(d[i], 1'b0);
      m.stop();
   endtask : wr

   // reads at the current pointer, nacks the last byte, then sees the line released
   task automatic rd(input logic [7:0] exp[$]);
      logic [7:0] r;
      logic a;
      m.start();
      put(SLAVE_ADDR_BYTE | 8'h01, 1'b0);
      foreach (exp[i]) begin
         m.xfer(8'hFF, i == exp.size() - 1, r, a);
         check(r, exp[i]);
      end
      #80;
      check({7'h00, sda}, 8'h01);
      m.stop();
   endtask : rd

   task automatic t_reset();
      rd({8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00});
   endtask : t_reset

   task automatic t_wrap_write();
      wr(8'h06, {8'hFF, 8'hFF, 8'hFF, 8'hFF});
      rd({8'h00, 8'h01});
      set_ptr(8'hF6);
      rd({8'hFF, 8'hFF, 8'hFF, 8'h7F});
   endtask : t_wrap_write

   task automatic t_bad_addr();
      m.start();
      put(8'hA0, 1'b1);
      put(8'h00, 1'b1);
      put(8'h55, 1'b1);
      m.stop();
      set_ptr(8'h00);
      rd({8'hFF});
   endtask : t_bad_addr

   task automatic t_power();
      set_ptr(8'h03);
      tk(1);
      supply_ok = 1'b0;
      tk(10);
      check({7'h00, sda_oe}, 8'h00);
      put(8'h05, 1'b1);
      m.stop();
      m.start();
      put(SLAVE_ADDR_BYTE, 1'b1);
      m.stop();
      tk(1);
      supply_ok = 1'b1;
      tk(10);
      rd({8'hFF, 8'h7F, 8'h00, 8'h01});
   endtask : t_power

   task automatic pulse_tick();
      tk(1);
      tick = 1'b1;
      tk(6);
      tick = 1'b0;
      tk(6);
   endtask : pulse_tick

   task automatic t_clock();
      pulse_tick();
      set_ptr(8'h00);
      rd({8'hFF});
      for (int ceb = 1; ceb >= 0; ceb--) begin
         wr(8'h00, {8'h59, 8'h59, ceb ? 8'hA3 : 8'h23, 8'h07, 8'h31, 8'h12, 8'h99});
         pulse_tick();
         set_ptr(8'h00);
         rd({8'h00, 8'h00, ceb ? 8'hC0 : 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
      end
   endtask : t_clock

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      supply_ok = 1'b1;
      tick = 1'b0;
      tk(10);
      reset_n = 1'b1;
      tk(125);
      t_reset();
      t_wrap_write();
      t_bad_addr();
      t_power();
      t_clock();
      stop_test();
   end

   // about 84 bytes at 0.72 us each; the limit leaves ample margin
   initial begin
      #500000;
      failures++;
      stop_test();
   end
endmodule : tb_top
